// *** logic/gdp_pkg.sv ***
// How it works
// [RL1] bus address only 01 to 31 accepted
// [RL2] new address takes effect at once
// [RL3] address after reset is 07
// [RL4] controller sends interface messages with ATN low; port takes them only with atnIn high
// [RL5] device clear resets parser, unaddressed too
// [RL6] selected clear only when listen addressed
// [RL7] device bytes carry 7-bit codes, ATN high; port sends and takes them only with atnIn low
// [RL8] talk only with reply data and talk addressed
// [RL9] new command line discards pending reply
// [RL10] fault latches and raises service request
// [RL11] latched fault cleared only by reset command
// [RL12] serial poll returns current status byte
// [RL13] poll read releases request until new fault
package gdp_pkg;
    // register byte addresses
    localparam logic [7:0] REG_ADDR      = 8'h00;
    localparam logic [7:0] REG_CTRL      = 8'h04;
    localparam logic [7:0] REG_RXDATA    = 8'h08;
    localparam logic [7:0] REG_TXDATA    = 8'h0c;
    localparam logic [7:0] REG_STATE     = 8'h10;
    localparam logic [7:0] REG_INT_STAT  = 8'h14;
    localparam logic [7:0] REG_INT_MASK  = 8'h18;
    // bus address limits and reset value
    localparam logic [4:0] ADDR_MIN      = 5'h01;
    localparam logic [4:0] ADDR_MAX      = 5'h1f;
    localparam logic [4:0] ADDR_DEFAULT  = 5'h07;
    // control register fields
    localparam int         CTRL_FAULT_CLR = 0;
    // state register fields
    localparam int         ST_LISTEN     = 0;
    localparam int         ST_TALK       = 1;
    localparam int         ST_RXFULL     = 2;
    localparam int         ST_SPMODE     = 3;
    localparam int         ST_SRQ        = 4;
    localparam int         ST_FAULT_LSB  = 8;
    localparam int         ST_COUNT_LSB  = 16;
    // interrupt event bits
    localparam int         EV_RX         = 0;
    localparam int         EV_CLEAR      = 1;
    localparam int         EV_FAULT      = 2;
    localparam int         EV_POLLED     = 3;
    localparam int         EV_REFUSED    = 4;
    localparam int         EV_DISCARD    = 5;
    localparam int         EV_NUM        = 6;
    localparam int         FAULT_NUM     = 6;
    // interface message codes, 7 bits
    localparam logic [6:0] CMD_DCL       = 7'h14;
    localparam logic [6:0] CMD_SDC       = 7'h04;
    localparam logic [6:0] CMD_SPE       = 7'h18;
    localparam logic [6:0] CMD_SPD       = 7'h19;
    localparam logic [6:0] CMD_UNL       = 7'h3f;
    localparam logic [6:0] CMD_UNT       = 7'h5f;
    localparam logic [1:0] GRP_LISTEN    = 2'h1;
    localparam logic [1:0] GRP_TALK      = 2'h2;

    typedef enum logic [1:0] {
        A_IDLE  = 2'b00,
        A_READY = 2'b01,
        A_HOLD  = 2'b10
    } gdp_acc_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_WAIT = 2'b01,
        S_DAV  = 2'b10
    } gdp_src_t;
endpackage

// *** logic/gdp_remote_port.sv ***
`timescale 1ns/100ps
module gdp_remote_port import gdp_pkg::*; #(
    parameter int TX_DEPTH = 16
) (
    input  wire logic                 clock,
    input  wire logic                 reset_n,
    input  wire logic [7:0]           regAddr,
    input  wire logic [31:0]          regWdata,
    input  wire logic                 regWr,
    input  wire logic                 regRd,
    output logic      [31:0]          regRdata,
    input  wire logic [7:0]           dioIn,
    output logic      [7:0]           dioOut,
    output logic                      dioOe,
    input  wire logic                 atnIn,
    output logic                      eoiOe,
    input  wire logic                 davIn,
    output logic                      davOe,
    input  wire logic                 nrfdIn,
    output logic                      nrfdOe,
    input  wire logic                 ndacIn,
    output logic                      ndacOe,
    output logic                      srqOe,
    input  wire logic [FAULT_NUM-1:0] faultIn,
    output logic                      parserClear,
    output logic                      irq
);
    localparam int PW = $clog2(TX_DEPTH);

    if (TX_DEPTH < 2 || TX_DEPTH > 256 || (1 << PW) != TX_DEPTH) begin : gDepthCheck
        $error("TX_DEPTH must be a power of two from 2 to 256");
    end

    function automatic logic isAddrCmd(input logic [6:0] c, input logic [1:0] grp, input logic [4:0] a);
        isAddrCmd = (c == {grp, a});
    endfunction

    gdp_acc_t           accState_r, accState_nxt;
    gdp_src_t           srcState_r, srcState_nxt;
    logic [4:0]         busAddr_r;
    logic               listen_r, talk_r, spMode_r, spSent_r;
    logic [7:0]         rxData_r;
    logic               rxFull_r;
    logic [7:0]         txMem [TX_DEPTH];
    logic [PW-1:0]      txWrPtr_r, txRdPtr_r;
    logic [PW:0]        txCount_r, txCount_nxt;
    logic [FAULT_NUM-1:0] faultLatch_r;
    logic               srqPending_r;
    logic [EV_NUM-1:0]  intStat_r, intMask_r;
    logic [7:0]         dioOut_r;
    logic               dioOe_r, eoiOe_r, davOe_r, nrfdOe_r, ndacOe_r;
    logic               srqOe_r;
    logic               parserClear_r, irq_r;
    logic [31:0]        regRdata_r;
    logic               seenCycle_r;

    // decode of register accesses
    wire        wrAddr    = regWr && regAddr == REG_ADDR;
    wire        wrCtrl    = regWr && regAddr == REG_CTRL;
    wire        wrTx      = regWr && regAddr == REG_TXDATA;
    wire        wrIntStat = regWr && regAddr == REG_INT_STAT;
    wire        wrIntMask = regWr && regAddr == REG_INT_MASK;
    wire        rdRx      = regRd && regAddr == REG_RXDATA;
    wire        addrOk    = regWdata[31:5] == 27'h0 && regWdata[4:0] >= ADDR_MIN && regWdata[4:0] <= ADDR_MAX;
    wire        faultClr  = wrCtrl && regWdata[CTRL_FAULT_CLR];

    // acceptor side: bytes taken while ATN, or while listen addressed and not talk addressed
    // a talker that also listens would take its own bytes and flush its reply
    wire        accActive = atnIn || (listen_r && !talk_r);
    wire        accept    = accState_r == A_READY && davIn && !nrfdOe_r;
    wire [6:0]  cmd       = dioIn[6:0];
    wire        cmdAccept = accept && atnIn;
    wire        devAccept = accept && !atnIn;
    wire        isMla     = cmdAccept && isAddrCmd(cmd, GRP_LISTEN, busAddr_r);
    wire        isMta     = cmdAccept && isAddrCmd(cmd, GRP_TALK, busAddr_r);
    wire        isOta     = cmdAccept && cmd[6:5] == GRP_TALK && !isAddrCmd(cmd, GRP_TALK, busAddr_r);
    wire        isUnl     = cmdAccept && cmd == CMD_UNL && !isMla;
    wire        isUnt     = cmdAccept && cmd == CMD_UNT;
    wire        isSpe     = cmdAccept && cmd == CMD_SPE;
    wire        isSpd     = cmdAccept && cmd == CMD_SPD;
    wire        devClear  = cmdAccept && (cmd == CMD_DCL || (cmd == CMD_SDC && listen_r)); // RL5 RL6
    wire        discard   = devAccept && txCount_r != '0; // RL9

    // source side
    wire        txHave    = txCount_r != '0;
    wire        srcGo     = talk_r && !atnIn && (spMode_r ? !spSent_r : txHave); // RL8
    wire [7:0]  statusByte = {1'b0, srqPending_r, faultLatch_r}; // RL12
    wire [7:0]  srcByte   = spMode_r ? statusByte : {1'b0, txMem[txRdPtr_r][6:0]}; // RL7
    wire        srcDone   = srcState_r == S_DAV && !ndacIn && !atnIn;
    wire        pollDone  = srcDone && spMode_r;
    wire        txPop     = srcDone && !spMode_r;
    wire        txPush    = wrTx && !txCount_r[PW];
    wire        newFault  = |(faultIn & ~faultLatch_r);

    wire [EV_NUM-1:0] events = {discard, wrAddr && !addrOk, pollDone, newFault, devClear, devAccept};

    // upper pad follows the reply counter width
    wire [31:0] stateWord = {{(15-PW){1'b0}}, txCount_r, 2'h0, faultLatch_r, 3'h0,
                             srqPending_r, spMode_r, rxFull_r, talk_r, listen_r};

    // read mux, unmapped addresses read zero
    wire [31:0] rdMux =
        regAddr == REG_ADDR     ? {27'h0, busAddr_r} :
        regAddr == REG_RXDATA   ? {24'h0, rxData_r} :
        regAddr == REG_STATE    ? stateWord :
        regAddr == REG_INT_STAT ? {26'h0, intStat_r} :
        regAddr == REG_INT_MASK ? {26'h0, intMask_r} : 32'h0;

    always_comb begin
        accState_nxt = accState_r;
        case (accState_r)
            A_IDLE:  if (accActive) accState_nxt = A_READY;
            A_READY: if (accept) accState_nxt = A_HOLD;
                     else if (!accActive) accState_nxt = A_IDLE;
            A_HOLD:  if (!davIn) accState_nxt = A_IDLE;
            default: accState_nxt = A_IDLE;
        endcase
    end

    always_comb begin
        srcState_nxt = srcState_r;
        case (srcState_r)
            S_IDLE:  if (srcGo) srcState_nxt = S_WAIT;
            S_WAIT:  if (atnIn) srcState_nxt = S_IDLE;
                     else if (!nrfdIn) srcState_nxt = S_DAV;
            S_DAV:   if (atnIn || !ndacIn) srcState_nxt = S_IDLE;
            default: srcState_nxt = S_IDLE;
        endcase
    end

    // flush wins over push and pop
    always_comb begin
        txCount_nxt = txCount_r;
        if (devClear || discard) txCount_nxt = '0;
        else if (txPush && !txPop) txCount_nxt = txCount_r + 1'b1;
        else if (txPop && !txPush) txCount_nxt = txCount_r - 1'b1;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            accState_r <= A_IDLE;
            srcState_r <= S_IDLE;
        end else begin
            accState_r <= accState_nxt;
            srcState_r <= srcState_nxt;
        end
    end

    // bus address, refused values leave the old one in place
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) busAddr_r <= ADDR_DEFAULT; // RL3
        else if (wrAddr && addrOk) busAddr_r <= regWdata[4:0]; // RL1 RL2
    end

    // addressing state from interface messages
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            listen_r <= 1'b0;
            talk_r   <= 1'b0;
            spMode_r <= 1'b0;
            spSent_r <= 1'b0;
        end else begin
            if (isMla) listen_r <= 1'b1;
            else if (isUnl) listen_r <= 1'b0;
            if (isMta) talk_r <= 1'b1;
            else if (isUnt || isOta) talk_r <= 1'b0;
            if (isSpe) spMode_r <= 1'b1;
            else if (isSpd) spMode_r <= 1'b0;
            if (isSpe) spSent_r <= 1'b0;
            else if (pollDone) spSent_r <= 1'b1;
        end
    end

    // single receive holding byte; NRFD stalls the controller while full
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rxData_r <= 8'h00;
            rxFull_r <= 1'b0;
        end else begin
            if (devAccept) rxData_r <= dioIn;
            if (devAccept) rxFull_r <= 1'b1;
            else if (devClear || rdRx) rxFull_r <= 1'b0; // RL5 RL6
        end
    end

    always_ff @(posedge clock) begin
        if (txPush) txMem[txWrPtr_r] <= regWdata[7:0];
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            txWrPtr_r <= '0;
            txRdPtr_r <= '0;
            txCount_r <= '0;
        end else begin
            txCount_r <= txCount_nxt;
            if (devClear || discard) begin
                txWrPtr_r <= '0;
                txRdPtr_r <= '0;
            end else begin
                if (txPush) txWrPtr_r <= txWrPtr_r + 1'b1;
                if (txPop) txRdPtr_r <= txRdPtr_r + 1'b1;
            end
        end
    end

    // faults stay until the reset command; a fault arriving now wins
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            faultLatch_r <= '0;
            srqPending_r <= 1'b0;
        end else begin
            faultLatch_r <= (faultLatch_r & ~{FAULT_NUM{faultClr}}) | faultIn; // RL10 RL11
            srqPending_r <= newFault || (srqPending_r && !pollDone); // RL10 RL13
        end
    end

    // bus pin drivers, all registered
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            dioOut_r <= 8'h00;
            dioOe_r  <= 1'b0;
            eoiOe_r  <= 1'b0;
            davOe_r  <= 1'b0;
            nrfdOe_r <= 1'b0;
            ndacOe_r <= 1'b0;
            srqOe_r  <= 1'b0;
        end else begin
            if (srcState_r == S_IDLE && srcGo) dioOut_r <= srcByte;
            dioOe_r  <= srcState_nxt != S_IDLE; // RL8
            eoiOe_r  <= srcState_nxt != S_IDLE && !spMode_r && txCount_r == 1;
            davOe_r  <= srcState_nxt == S_DAV;
            nrfdOe_r <= accState_nxt == A_HOLD ||
                        (accState_nxt == A_READY && !atnIn && rxFull_r && !devAccept) ||
                        (accState_nxt == A_READY && !atnIn && devAccept);
            ndacOe_r <= accState_nxt == A_READY;
            srqOe_r  <= srqPending_r; // RL13
        end
    end

    // sticky status: write one clears, a new event wins
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            intStat_r     <= '0;
            intMask_r     <= '0;
            irq_r         <= 1'b0;
            parserClear_r <= 1'b0;
            regRdata_r    <= 32'h0;
            seenCycle_r   <= 1'b0;
        end else begin
            intStat_r     <= (intStat_r & ~(wrIntStat ? regWdata[EV_NUM-1:0] : '0)) | events;
            if (wrIntMask) intMask_r <= regWdata[EV_NUM-1:0];
            irq_r         <= |(intStat_r & intMask_r);
            parserClear_r <= devClear; // RL5 RL6
            regRdata_r    <= regRd ? rdMux : 32'h0;
            seenCycle_r   <= 1'b1;
        end
    end

    assign dioOut      = dioOut_r;
    assign dioOe       = dioOe_r;
    assign eoiOe       = eoiOe_r;
    assign davOe       = davOe_r;
    assign nrfdOe      = nrfdOe_r;
    assign ndacOe      = ndacOe_r;
    assign srqOe       = srqOe_r;
    assign parserClear = parserClear_r;
    assign irq         = irq_r;
    assign regRdata    = regRdata_r;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    sequence seqPollDone;
        pollDone && !newFault;
    endsequence
    sequence seqReleased;
        !srqPending_r ##1 !srqOe_r;
    endsequence

    addr_range_a: assert property (busAddr_r >= ADDR_MIN && busAddr_r <= ADDR_MAX) // RL1
        else $error("bus address out of range");
    addr_take_a: assert property (wrAddr && addrOk |=> busAddr_r == $past(regWdata[4:0])) // RL2
        else $error("new bus address not taken at once");
    addr_default_a: assert property (!seenCycle_r |-> busAddr_r == ADDR_DEFAULT) // RL3
        else $error("bus address not default after reset");
    dcl_clear_a: assert property (cmdAccept && cmd == CMD_DCL |=> parserClear_r && !rxFull_r && txCount_r == 0) // RL5
        else $error("device clear not carried out");
    sdc_gate_a: assert property (cmdAccept && cmd == CMD_SDC && !listen_r |=> !parserClear_r) // RL6
        else $error("selected clear acted while unaddressed");
    tx_seven_a: assert property (dioOe_r |-> !dioOut_r[7] && talk_r) // RL7 RL8
        else $error("bad byte or talking unaddressed");
    line_discard_a: assert property (discard |=> txCount_r == 0 ##1 !dioOe_r || spMode_r) // RL9
        else $error("reply kept across new command line");
    fault_srq_a: assert property (newFault |=> srqPending_r ##1 srqOe_r) // RL10
        else $error("fault raised no service request");
    fault_hold_a: assert property (!faultClr |=> (faultLatch_r & $past(faultLatch_r)) == $past(faultLatch_r)) // RL11
        else $error("fault dropped without reset command");
    poll_byte_a: assert property (srcState_r == S_IDLE && srcGo && spMode_r |=> dioOut_r == $past(statusByte)) // RL12
        else $error("poll byte does not match status");
    poll_release_a: assert property (seqPollDone |=> seqReleased) // RL13
        else $error("service request held after poll");
endmodule

// *** tb/gdp_ctrl_model.sv ***
`timescale 1ns/100ps
module gdp_ctrl_model (
    input  wire logic       clock,
    input  wire logic       davLine,
    input  wire logic       nrfdLine,
    input  wire logic       ndacLine,
    input  wire logic [7:0] dioLine,
    output logic      [7:0] dioDrv,
    output logic            atnDrv,
    output logic            davDrv,
    output logic            nrfdDrv,
    output logic            ndacDrv
);
    initial begin
        dioDrv = 8'h00;
        atnDrv = 1'b0;
        davDrv = 1'b0;
        nrfdDrv = 1'b0;
        ndacDrv = 1'b0;
    end

    // bounded waits: an unaddressed listener never answers, so do not hang
    task automatic send(input logic [7:0] b, input logic atn);
        int n;
        @(posedge clock);
        dioDrv <= b;
        atnDrv <= atn;
        nrfdDrv <= 1'b0;
        ndacDrv <= 1'b0;
        n = 0;
        do begin @(posedge clock); n++; end while ((nrfdLine || !ndacLine) && n < 8);
        davDrv <= 1'b1;
        n = 0;
        do begin @(posedge clock); n++; end while (ndacLine && n < 20);
        davDrv <= 1'b0;
        dioDrv <= ~b; // released lines do not keep the old value
        repeat (3) @(posedge clock);
    endtask

    task automatic recv(input int stall, output logic [7:0] b);
        int n;
        @(posedge clock);
        atnDrv <= 1'b0;
        nrfdDrv <= stall != 0;
        ndacDrv <= 1'b1;
        repeat (stall) @(posedge clock);
        if (stall != 0) nrfdDrv <= 1'b0;
        n = 0;
        do begin @(posedge clock); n++; end while (!davLine && n < 50);
        b = dioLine;
        nrfdDrv <= 1'b1;
        ndacDrv <= 1'b0;
        n = 0;
        do begin @(posedge clock); n++; end while (davLine && n < 20);
        ndacDrv <= 1'b1;
    endtask
endmodule

// *** tb/tb.sv ***
`timescale 1ns/100ps
module tb import gdp_pkg::*;;
    logic        clock;
    logic        reset_n;
    logic [7:0]  regAddr;
    logic [31:0] regWdata;
    logic        regWr;
    logic        regRd;
    logic [31:0] regRdata;
    logic [7:0]  dioOut;
    logic        dioOe;
    logic        eoiOe;
    logic        davOe;
    logic        nrfdOe;
    logic        ndacOe;
    logic        srqOe;
    logic [5:0]  faultIn;
    logic        parserClear;
    logic        irq;
    logic [7:0]  dioDrv;
    logic        atnDrv;
    logic        davDrv;
    logic        nrfdDrv;
    logic        ndacDrv;
    wire  [7:0]  dioLine = dioOe ? dioOut : dioDrv;
    wire         davLine = davDrv | davOe;
    wire         nrfdLine = nrfdDrv | nrfdOe;
    wire         ndacLine = ndacDrv | ndacOe;
    int          failures = 0;
    int          tests_run = 0;
    int          clrCount = 0;
    int          dioSeen = 0;
    int          eoiSeen = 0;
    logic [31:0] d;
    logic [7:0]  b;

    gdp_remote_port i_dut (.clock(clock), .reset_n(reset_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .dioIn(dioLine), .dioOut(dioOut),
        .dioOe(dioOe), .atnIn(atnDrv), .eoiOe(eoiOe), .davIn(davLine), .davOe(davOe), .nrfdIn(nrfdLine),
        .nrfdOe(nrfdOe), .ndacIn(ndacLine), .ndacOe(ndacOe), .srqOe(srqOe), .faultIn(faultIn),
        .parserClear(parserClear), .irq(irq));
    gdp_ctrl_model i_ctrl (.clock(clock), .davLine(davLine), .nrfdLine(nrfdLine), .ndacLine(ndacLine),
        .dioLine(dioLine), .dioDrv(dioDrv), .atnDrv(atnDrv), .davDrv(davDrv), .nrfdDrv(nrfdDrv),
        .ndacDrv(ndacDrv));

    always #50 clock = ~clock;
    always @(posedge clock) begin
        if (parserClear === 1'b1) clrCount++;
        if (dioOe === 1'b1) dioSeen++;
        if (eoiOe === 1'b1 && davOe === 1'b1) eoiSeen++;
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        regAddr <= a;
        regWdata <= v;
        regWr <= 1'b1;
        @(posedge clock);
        regWr <= 1'b0;
        @(posedge clock);
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clock);
        regRd <= 1'b0;
        #1 v = regRdata;
        @(posedge clock);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic done(input string name);
        $display("test %s finished", name);
    endtask

    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        tally_and_finish;
    end

    initial begin
        logic [4:0] aTry [4] = '{5'h00, 5'h00, 5'h1f, 5'h01};
        logic [5:0] aHi [4] = '{6'h00, 6'h20, 6'h00, 6'h00};
        logic [4:0] aExp [4] = '{5'h07, 5'h07, 5'h1f, 5'h01};
        clock = 1'b0;
        reset_n = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h0;
        regWr = 1'b0;
        regRd = 1'b0;
        faultIn = 6'h00;
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        @(posedge clock);
        rd(REG_ADDR, d); chk(d, 32'h7);
        rd(8'h1c, d); chk(d, 32'h0);
        done("reset");
        for (int i = 0; i < 4; i++) begin
            wr(REG_ADDR, {26'h0, aHi[i]} | {27'h0, aTry[i]});
            rd(REG_ADDR, d); chk(d, {27'h0, aExp[i]});
            if (i < 2) begin
                rd(REG_INT_STAT, d); chk(d & 32'h10, 32'h10);
                wr(REG_INT_STAT, 32'h3f);
            end
        end
        wr(REG_ADDR, 32'h5);
        i_ctrl.send(8'h25, 1'b1);
        rd(REG_STATE, d); chk(d & 32'h1, 32'h1);
        i_ctrl.send(8'h41, 1'b0);
        rd(REG_RXDATA, d); chk(d & 32'hff, 32'h41);
        done("address");
        i_ctrl.send({1'b0, CMD_SDC}, 1'b1);
        chk(clrCount, 1);
        i_ctrl.send({1'b0, CMD_UNL}, 1'b1);
        i_ctrl.send({1'b0, CMD_SDC}, 1'b1);
        chk(clrCount, 1);
        i_ctrl.send({1'b0, CMD_DCL}, 1'b1);
        chk(clrCount, 2);
        done("clear");
        wr(REG_TXDATA, 32'hc8);
        wr(REG_TXDATA, 32'h4b);
        i_ctrl.recv(0, b);
        chk(dioSeen, 0);
        i_ctrl.send(8'h45, 1'b1);
        i_ctrl.recv(0, b); chk(b, 8'h48);
        chk(eoiSeen, 0);
        i_ctrl.recv(3, b); chk(b, 8'h4b);
        chk(eoiSeen > 0, 1);
        rd(REG_STATE, d); chk(d >> 16, 32'h0);
        done("talk");
        i_ctrl.send({1'b0, CMD_UNT}, 1'b1);
        i_ctrl.send(8'h25, 1'b1);
        wr(REG_TXDATA, 32'h31);
        i_ctrl.send(8'h42, 1'b0);
        rd(REG_STATE, d); chk(d >> 16, 32'h0);
        rd(REG_INT_STAT, d); chk(d & 32'h20, 32'h20);
        rd(REG_RXDATA, d);
        done("discard");
        // mask only the fault event so irq follows that bit alone
        wr(REG_INT_STAT, 32'h3f);
        wr(REG_INT_MASK, 32'h4);
        faultIn <= 6'h04;
        @(posedge clock);
        faultIn <= 6'h00;
        repeat (3) @(posedge clock);
        chk(srqOe, 1'b1);
        chk(irq, 1'b1);
        rd(REG_STATE, d); chk(d & 32'h3f00, 32'h0400);
        wr(REG_INT_STAT, 32'h4);
        @(posedge clock);
        chk(irq, 1'b0);
        i_ctrl.send({1'b0, CMD_UNL}, 1'b1);
        i_ctrl.send({1'b0, CMD_SPE}, 1'b1);
        i_ctrl.send(8'h45, 1'b1);
        i_ctrl.recv(0, b); chk(b, 8'h44);
        repeat (4) @(posedge clock);
        chk(srqOe, 1'b0);
        i_ctrl.send({1'b0, CMD_SPD}, 1'b1);
        rd(REG_STATE, d); chk(d & 32'h3f00, 32'h0400);
        wr(REG_CTRL, 32'h1);
        rd(REG_STATE, d); chk(d & 32'h3f00, 32'h0);
        done("fault");
        tally_and_finish;
    end
endmodule
